// ---- design/vic_ctrl.sv ----
// vectored interrupt controller with normal and fast request outputs
// Behaviour
// - 54 sources, each routed normal or fast
// - thirty-two priority levels, of which only 0 to 30 can pass the mask and vector normal requests
// - two priority levels vector fast requests
// - internal inputs level sensitive, selectable polarity
// - port pins sense high, low, rise, fall, both
// - three off-chip lines request while high
// - nineteen port pins usable as interrupt sources
// - software priority mask on both request paths
// - each port pin output, input or interrupt
// - external input two held inactive
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module vic_ctrl
    import vic_pkg::*;
#(
    parameter int NUM_SRC = VIC_NUM_SRC,
    parameter int NUM_GPIO = VIC_NUM_GPIO
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [VIC_NUM_INT-1:0] int_src_i,
    input wire logic [VIC_NUM_EXT-1:0] ext_int_i,
    input wire logic [VIC_NUM_EXP-1:0] expanded_port_pins_i,
    input wire logic [VIC_NUM_SEC-1:0] secondary_port_pins_i,
    output logic [VIC_NUM_EXP-1:0] expanded_port_pins_o,
    output logic [VIC_NUM_EXP-1:0] expanded_port_pins_oe_o,
    output logic [VIC_NUM_SEC-1:0] secondary_port_pins_o,
    output logic [VIC_NUM_SEC-1:0] secondary_port_pins_oe_o,
    output logic irq_o,
    output logic fiq_o,
    output logic [VIC_SRC_W-1:0] irq_vec_o,
    output logic [VIC_SRC_W-1:0] fiq_vec_o,
    output logic int_o
);
    initial begin
        if (NUM_SRC != VIC_NUM_SRC || NUM_GPIO != VIC_NUM_GPIO) begin
            $error("vic_ctrl: source counts are fixed by the map");
        end
    end

    typedef struct packed {
        logic [VIC_NUM_INT-1:0] int_pol;
        logic [NUM_SRC-1:0] en;
        logic [NUM_SRC-1:0] sel_fiq;
        logic [VIC_PRIO_W-1:0] pmask;
        logic [NUM_GPIO-1:0] gp_dir;
        logic [NUM_GPIO-1:0] gp_out;
        logic [NUM_GPIO-1:0] gp_ie;
        logic [NUM_GPIO-1:0] gp_edge;
        logic [NUM_GPIO-1:0] gp_pol;
        logic [NUM_GPIO-1:0] gp_both;
        logic [NUM_GPIO-1:0] gp_prev;
        logic [NUM_GPIO-1:0] gp_lat;
        logic [VIC_EV_W-1:0] istat;
        logic [VIC_EV_W-1:0] imask;
        logic irq;
        logic fiq;
        logic [VIC_SRC_W-1:0] irq_vec;
        logic [VIC_SRC_W-1:0] fiq_vec;
        vic_rd_state_t rd_st;
        logic [7:0] rd_addr;
        logic [31:0] rdata;
    } vic_state_t;
    vic_state_t st_ff, nxt_st;

    logic [NUM_GPIO-1:0] gp_pins;
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] act;
    logic [NUM_SRC*VIC_SRC_W-1:0] prio_all;
    logic [VIC_SRC_W-1:0] prio_rd;
    logic prio_wr;
    logic [VIC_SRC_W-1:0] irq_win;
    logic [VIC_SRC_W-1:0] fiq_win;
    logic irq_any;
    logic fiq_any;
    logic [NUM_GPIO-1:0] gp_fire;

    assign gp_pins = {secondary_port_pins_i, expanded_port_pins_i};
    assign prio_wr = wr_i && addr_i >= VIC_REG_PRIO_BASE && addr_i <= VIC_REG_PRIO_TOP;

    vic_prio_mem #(
        .DEPTH(NUM_SRC),
        .WIDTH(VIC_SRC_W)
    ) u_prio (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(prio_wr),
        .wr_addr_i(6'(addr_i - VIC_REG_PRIO_BASE)),
        .wr_data_i(wdata_i[VIC_SRC_W-1:0]),
        .rd_addr_i(6'(addr_i - VIC_REG_PRIO_BASE)),
        .rd_data_o(prio_rd),
        .all_o(prio_all)
    );

    // priority field of source i: low bits rank, bit 5 unused
    function automatic logic [VIC_PRIO_W-1:0] prio_of(input logic [NUM_SRC*VIC_SRC_W-1:0] all, input int i);
        logic [VIC_SRC_W-1:0] p;
        p = all[i*VIC_SRC_W +: VIC_SRC_W];
        return p[VIC_PRIO_W-1:0];
    endfunction

    // gather source levels
    always_comb begin
        raw = '0;
        for (int i = 0; i < VIC_NUM_INT; i++) begin
            raw[i] = int_src_i[i] ^ st_ff.int_pol[i];
        end
        for (int i = 0; i < NUM_GPIO; i++) begin
            raw[VIC_GPIO_BASE + i] = st_ff.gp_lat[i];
        end
        raw[VIC_EXT_BASE] = ext_int_i[0];
        raw[VIC_EXT_BASE + 1] = ext_int_i[1];
        raw[VIC_EXT_BASE + 2] = ext_int_i[3];
    end

    // port pin sensing
    always_comb begin
        for (int i = 0; i < NUM_GPIO; i++) begin
            if (!st_ff.gp_edge[i]) begin
                gp_fire[i] = gp_pins[i] ^ ~st_ff.gp_pol[i];
            end else if (st_ff.gp_both[i]) begin
                gp_fire[i] = gp_pins[i] ^ st_ff.gp_prev[i];
            end else if (st_ff.gp_pol[i]) begin
                gp_fire[i] = gp_pins[i] & ~st_ff.gp_prev[i];
            end else begin
                gp_fire[i] = ~gp_pins[i] & st_ff.gp_prev[i];
            end
            // interrupt only when input and enabled
            gp_fire[i] = gp_fire[i] & st_ff.gp_ie[i] & ~st_ff.gp_dir[i];
        end
    end

    // priority selection
    always_comb begin
        logic [VIC_PRIO_W-1:0] best_i;
        logic [VIC_PRIO_W-1:0] best_f;
        logic [VIC_PRIO_W-1:0] p;
        best_i = '1;
        best_f = '1;
        p = '0;
        irq_any = 1'b0;
        fiq_any = 1'b0;
        irq_win = VIC_NO_SRC;
        fiq_win = VIC_NO_SRC;
        // mask hides levels at or above it
        for (int i = 0; i < NUM_SRC; i++) begin
            p = prio_of(prio_all, i);
            act[i] = raw[i] & st_ff.en[i] & (p < st_ff.pmask);
        end
        for (int i = 0; i < NUM_SRC; i++) begin
            p = prio_of(prio_all, i);
            if (act[i] && st_ff.sel_fiq[i]) begin
                // two fast levels from bit 0
                if (!fiq_any || (p[0] < best_f[0])) begin
                    best_f = p;
                    fiq_win = 6'(i);
                end
                fiq_any = 1'b1;
            end else if (act[i]) begin
                if (!irq_any || p < best_i) begin
                    best_i = p;
                    irq_win = 6'(i);
                end
                irq_any = 1'b1;
            end
        end
    end

    // next state and register access
    always_comb begin
        logic [NUM_GPIO-1:0] gclr;
        logic [VIC_EV_W-1:0] ev;
        nxt_st = st_ff;
        gclr = '0;
        ev = '0;
        nxt_st.gp_prev = gp_pins;
        nxt_st.rd_st = rd_i ? VIC_RD_DATA : VIC_RD_IDLE;
        nxt_st.rd_addr = addr_i;
        nxt_st.irq = irq_any;
        nxt_st.fiq = fiq_any;
        nxt_st.irq_vec = irq_win;
        nxt_st.fiq_vec = fiq_win;
        if (wr_i) begin
            case (addr_i)
                VIC_REG_INT_POL: nxt_st.int_pol = wdata_i;
                VIC_REG_EN_LO: nxt_st.en[31:0] = wdata_i;
                VIC_REG_EN_HI: nxt_st.en[NUM_SRC-1:32] = wdata_i[NUM_SRC-33:0];
                VIC_REG_SEL_LO: nxt_st.sel_fiq[31:0] = wdata_i;
                VIC_REG_SEL_HI: nxt_st.sel_fiq[NUM_SRC-1:32] = wdata_i[NUM_SRC-33:0];
                VIC_REG_PMASK: nxt_st.pmask = wdata_i[VIC_PRIO_W-1:0];
                VIC_REG_GP_DIR: nxt_st.gp_dir = wdata_i[NUM_GPIO-1:0];
                VIC_REG_GP_OUT: nxt_st.gp_out = wdata_i[NUM_GPIO-1:0];
                VIC_REG_GP_IE: nxt_st.gp_ie = wdata_i[NUM_GPIO-1:0];
                VIC_REG_GP_EDGE: nxt_st.gp_edge = wdata_i[NUM_GPIO-1:0];
                VIC_REG_GP_POL: nxt_st.gp_pol = wdata_i[NUM_GPIO-1:0];
                VIC_REG_GP_BOTH: nxt_st.gp_both = wdata_i[NUM_GPIO-1:0];
                VIC_REG_GP_CLR: gclr = wdata_i[NUM_GPIO-1:0];
                VIC_REG_IMASK: nxt_st.imask = wdata_i[VIC_EV_W-1:0];
                default: ;
            endcase
        end
        // edge latches clear by write, level modes track; set beats clear
        for (int i = 0; i < NUM_GPIO; i++) begin
            if (!st_ff.gp_edge[i]) begin
                nxt_st.gp_lat[i] = gp_fire[i];
            end else begin
                nxt_st.gp_lat[i] = gp_fire[i] | (st_ff.gp_lat[i] & ~gclr[i] & st_ff.gp_ie[i]);
            end
        end
        ev[VIC_EV_IRQ] = irq_any & ~st_ff.irq;
        ev[VIC_EV_FIQ] = fiq_any & ~st_ff.fiq;
        ev[VIC_EV_GPIO] = |gp_fire;
        if (rd_i && addr_i == VIC_REG_ISTAT) begin
            nxt_st.istat = ev;
        end else begin
            nxt_st.istat = st_ff.istat | ev;
        end
        if (rd_i) begin
            case (addr_i)
                VIC_REG_INT_POL: nxt_st.rdata = st_ff.int_pol;
                VIC_REG_EN_LO: nxt_st.rdata = st_ff.en[31:0];
                VIC_REG_EN_HI: nxt_st.rdata = 32'(st_ff.en[NUM_SRC-1:32]);
                VIC_REG_SEL_LO: nxt_st.rdata = st_ff.sel_fiq[31:0];
                VIC_REG_SEL_HI: nxt_st.rdata = 32'(st_ff.sel_fiq[NUM_SRC-1:32]);
                VIC_REG_PMASK: nxt_st.rdata = 32'(st_ff.pmask);
                VIC_REG_RAW_LO: nxt_st.rdata = raw[31:0];
                VIC_REG_RAW_HI: nxt_st.rdata = 32'(raw[NUM_SRC-1:32]);
                VIC_REG_IRQ_VEC: nxt_st.rdata = 32'(st_ff.irq_vec);
                VIC_REG_FIQ_VEC: nxt_st.rdata = 32'(st_ff.fiq_vec);
                VIC_REG_GP_DIR: nxt_st.rdata = 32'(st_ff.gp_dir);
                VIC_REG_GP_OUT: nxt_st.rdata = 32'(st_ff.gp_out);
                VIC_REG_GP_IN: nxt_st.rdata = 32'(gp_pins);
                VIC_REG_GP_IE: nxt_st.rdata = 32'(st_ff.gp_ie);
                VIC_REG_GP_EDGE: nxt_st.rdata = 32'(st_ff.gp_edge);
                VIC_REG_GP_POL: nxt_st.rdata = 32'(st_ff.gp_pol);
                VIC_REG_GP_BOTH: nxt_st.rdata = 32'(st_ff.gp_both);
                VIC_REG_GP_CLR: nxt_st.rdata = 32'(st_ff.gp_lat);
                VIC_REG_ISTAT: nxt_st.rdata = 32'(st_ff.istat);
                VIC_REG_IMASK: nxt_st.rdata = 32'(st_ff.imask);
                default: nxt_st.rdata = VIC_ZERO32;
            endcase
        end else begin
            nxt_st.rdata = VIC_ZERO32;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
            st_ff.pmask <= VIC_PMASK_RST;
            st_ff.irq_vec <= VIC_NO_SRC;
            st_ff.fiq_vec <= VIC_NO_SRC;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // priority slots read from the memory one cycle later
    always_comb begin
        rdata_o = st_ff.rdata;
        if (st_ff.rd_st == VIC_RD_DATA && st_ff.rd_addr >= VIC_REG_PRIO_BASE
            && st_ff.rd_addr <= VIC_REG_PRIO_TOP) begin
            rdata_o = 32'(prio_rd);
        end
    end

    assign expanded_port_pins_o = st_ff.gp_out[VIC_NUM_EXP-1:0];
    assign expanded_port_pins_oe_o = st_ff.gp_dir[VIC_NUM_EXP-1:0];
    assign secondary_port_pins_o = st_ff.gp_out[NUM_GPIO-1:VIC_NUM_EXP];
    assign secondary_port_pins_oe_o = st_ff.gp_dir[NUM_GPIO-1:VIC_NUM_EXP];
    assign irq_o = st_ff.irq;
    assign fiq_o = st_ff.fiq;
    assign irq_vec_o = st_ff.irq_vec;
    assign fiq_vec_o = st_ff.fiq_vec;
    assign int_o = |(st_ff.istat & st_ff.imask);
endmodule
`default_nettype wire

// ---- design/vic_pkg.sv ----
// package of constants for the vectored interrupt controller
package vic_pkg;
    localparam int VIC_NUM_SRC = 54;
    localparam int VIC_NUM_INT = 32;
    localparam int VIC_NUM_EXT = 4;
    localparam int VIC_EXT_UNUSED = 2;
    localparam int VIC_NUM_GPIO = 19;
    localparam int VIC_NUM_EXP = 16;
    localparam int VIC_NUM_SEC = 3;
    localparam int VIC_IRQ_PRIO = 32;
    localparam int VIC_FIQ_PRIO = 2;
    localparam int VIC_GPIO_BASE = 32;
    localparam int VIC_EXT_BASE = 51;
    localparam int VIC_PRIO_W = 5;
    localparam int VIC_SRC_W = 6;

    localparam logic [7:0] VIC_REG_INT_POL = 8'h00;
    localparam logic [7:0] VIC_REG_EN_LO = 8'h01;
    localparam logic [7:0] VIC_REG_EN_HI = 8'h02;
    localparam logic [7:0] VIC_REG_SEL_LO = 8'h03;
    localparam logic [7:0] VIC_REG_SEL_HI = 8'h04;
    localparam logic [7:0] VIC_REG_PMASK = 8'h05;
    localparam logic [7:0] VIC_REG_RAW_LO = 8'h06;
    localparam logic [7:0] VIC_REG_RAW_HI = 8'h07;
    localparam logic [7:0] VIC_REG_IRQ_VEC = 8'h08;
    localparam logic [7:0] VIC_REG_FIQ_VEC = 8'h09;
    localparam logic [7:0] VIC_REG_GP_DIR = 8'h0A;
    localparam logic [7:0] VIC_REG_GP_OUT = 8'h0B;
    localparam logic [7:0] VIC_REG_GP_IN = 8'h0C;
    localparam logic [7:0] VIC_REG_GP_IE = 8'h0D;
    localparam logic [7:0] VIC_REG_GP_EDGE = 8'h0E;
    localparam logic [7:0] VIC_REG_GP_POL = 8'h0F;
    localparam logic [7:0] VIC_REG_GP_BOTH = 8'h10;
    localparam logic [7:0] VIC_REG_GP_CLR = 8'h11;
    localparam logic [7:0] VIC_REG_ISTAT = 8'h12;
    localparam logic [7:0] VIC_REG_IMASK = 8'h13;
    localparam logic [7:0] VIC_REG_PRIO_BASE = 8'h20;
    localparam logic [7:0] VIC_REG_PRIO_TOP = 8'h55;

    localparam logic [4:0] VIC_PMASK_RST = 5'h1F;
    localparam logic [5:0] VIC_NO_SRC = 6'h3F;
    localparam logic [31:0] VIC_ZERO32 = 32'h0000_0000;
    localparam int VIC_EV_W = 3;
    localparam int VIC_EV_IRQ = 0;
    localparam int VIC_EV_FIQ = 1;
    localparam int VIC_EV_GPIO = 2;

    typedef enum logic [1:0] {
        VIC_RD_IDLE = 2'b00,
        VIC_RD_DATA = 2'b01
    } vic_rd_state_t;
endpackage

// ---- design/vic_prio_mem.sv ----
// per-source priority memory, registered read
`timescale 1ns/100ps
`default_nettype none
module vic_prio_mem #(
    parameter int DEPTH = 54,
    parameter int WIDTH = 6
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [5:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [5:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o,
    output logic [DEPTH*WIDTH-1:0] all_o
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd;
    } vic_mem_state_t;
    vic_mem_state_t st_ff, nxt_st;

    initial begin
        if (DEPTH > 64 || WIDTH < 1) $error("vic_prio_mem: bad geometry");
    end

    always_comb begin
        nxt_st = st_ff;
        if (wr_en_i && int'(wr_addr_i) < DEPTH) begin
            nxt_st.mem[wr_addr_i] = wr_data_i;
        end
        nxt_st.rd = (int'(rd_addr_i) < DEPTH) ? st_ff.mem[rd_addr_i] : '0;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data_o = st_ff.rd;
    assign all_o = st_ff.mem;
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
module tb
    import vic_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = VIC_ZERO32;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic [31:0] int_src_i = VIC_ZERO32;
    logic [3:0] ext_int_i = 4'h0;
    logic [15:0] expanded_port_pins_i = 16'h0000;
    logic [2:0] secondary_port_pins_i = 3'h0;
    logic [15:0] expanded_port_pins_o, expanded_port_pins_oe_o;
    logic [2:0] secondary_port_pins_o, secondary_port_pins_oe_o;
    logic irq_o, fiq_o, int_o;
    logic [5:0] irq_vec_o, fiq_vec_o;
    logic [1:0] taken;
    logic rd_d = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] r;
    logic [4:0] md;
    // edge, both, polarity, idle level, active level
    logic [4:0] modes[5] = '{5'h05, 5'h02, 5'h15, 5'h12, 5'h1E};
    logic [3:0] ext_pat[4] = '{4'h4, 4'h8, 4'hA, 4'h3};
    logic [6:0] ext_exp[4] = '{7'h3F, 7'h75, 7'h74, 7'h73};
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    integer seed = 32'hf9f2_d914;
    vic_ctrl dut_u (.*);
    vic_core_model core_u (.ref_clk_i, .rst_n_i, .irq_i(irq_o), .fiq_i(fiq_o), .taken_o(taken));
    always #5 ref_clk_i = ~ref_clk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge ref_clk_i) rd_d <= rd_i;
    always @(negedge ref_clk_i) begin
        if (rd_d && exp_q.size() > 0) begin
            chk(rdata_o, exp_q.pop_front());
        end
    end
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd_reg(VIC_REG_PMASK, 32'h0000_001F);
        rd_reg(8'h14, VIC_ZERO32);
        tick(1);
        chk(32'({irq_o, fiq_o, irq_vec_o, fiq_vec_o}), 32'h0000_0FFF);
        // normal path: source 9 active low at level 1 beats source 5 at level 3
        wr_reg(VIC_REG_PRIO_BASE + 8'h05, 32'h0000_0003);
        wr_reg(VIC_REG_PRIO_BASE + 8'h09, 32'h0000_0001);
        wr_reg(VIC_REG_INT_POL, 32'h0000_0200);
        @(posedge ref_clk_i);
        int_src_i <= ($random(seed) & 32'hFFFF_FD7F) | 32'h0000_0020;
        wr_reg(VIC_REG_EN_LO, 32'h0000_0220);
        tick(2);
        rd_reg(VIC_REG_IRQ_VEC, 32'h0000_0009);
        rd_reg(VIC_REG_PRIO_BASE + 8'h09, 32'h0000_0001);
        @(posedge ref_clk_i);
        int_src_i[9] <= 1'b1;
        tick(2);
        chk(32'(irq_vec_o), 32'h0000_0005);
        wr_reg(VIC_REG_PMASK, 32'h0000_0003);
        tick(2);
        chk(32'(irq_o), VIC_ZERO32);
        wr_reg(VIC_REG_PMASK, VIC_ZERO32);
        wr_reg(VIC_REG_PMASK, 32'h0000_0004);
        tick(2);
        chk(32'(irq_o), 32'h0000_0001);
        // fast path looks only at the low level bit: 7 (even) beats 5 (odd)
        wr_reg(VIC_REG_PRIO_BASE + 8'h05, 32'h0000_0001);
        wr_reg(VIC_REG_PRIO_BASE + 8'h07, 32'h0000_0002);
        wr_reg(VIC_REG_SEL_LO, 32'h0000_00A0);
        wr_reg(VIC_REG_EN_LO, 32'h0000_00A0);
        @(posedge ref_clk_i);
        int_src_i[7] <= 1'b1;
        tick(2);
        chk(32'({irq_o, fiq_o, fiq_vec_o}), 32'h0000_0047);
        wr_reg(VIC_REG_PMASK, 32'h0000_0002);
        tick(2);
        chk(32'({irq_o, fiq_o, fiq_vec_o}), 32'h0000_0045);
        // off-chip lines, line two has no pin
        wr_reg(VIC_REG_EN_LO, VIC_ZERO32);
        wr_reg(VIC_REG_PMASK, 32'h0000_001F);
        wr_reg(VIC_REG_EN_HI, 32'h0038_0000);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk_i);
            ext_int_i <= ext_pat[i];
            tick(2);
            chk(32'({irq_o, irq_vec_o}), 32'(ext_exp[i]));
        end
        // port pin 17 is source 49, every sensing mode
        wr_reg(VIC_REG_EN_HI, 32'h0002_0000);
        wr_reg(VIC_REG_GP_IE, 32'h0002_0000);
        for (int m = 0; m < 5; m++) begin
            md = modes[m];
            @(posedge ref_clk_i);
            secondary_port_pins_i[1] <= md[1];
            wr_reg(VIC_REG_GP_EDGE, 32'(md[4]) << 17);
            wr_reg(VIC_REG_GP_POL, 32'(md[2]) << 17);
            wr_reg(VIC_REG_GP_BOTH, 32'(md[3]) << 17);
            wr_reg(VIC_REG_GP_CLR, 32'h0002_0000);
            tick(3);
            chk(32'(irq_o), VIC_ZERO32);
            @(posedge ref_clk_i);
            secondary_port_pins_i[1] <= md[0];
            tick(4);
            chk(32'({irq_o, irq_vec_o}), 32'h0000_0071);
            wr_reg(VIC_REG_GP_CLR, 32'h0002_0000);
            tick(3);
            chk(32'(irq_o), 32'(!md[4]));
        end
        // event status, mask and the level interrupt
        rd_reg(VIC_REG_ISTAT, 32'h0000_0007);
        wr_reg(VIC_REG_IMASK, 32'h0000_0004);
        @(posedge ref_clk_i);
        secondary_port_pins_i[1] <= 1'b1;
        tick(4);
        chk(32'({int_o, irq_o}), 32'h0000_0003);
        rd_reg(VIC_REG_ISTAT, 32'h0000_0005);
        tick(1);
        chk(32'(int_o), VIC_ZERO32);
        r = $random(seed);
        wr_reg(VIC_REG_GP_DIR, r);
        wr_reg(VIC_REG_GP_OUT, ~r);
        tick(1);
        chk(32'({secondary_port_pins_oe_o, expanded_port_pins_oe_o}), 32'(r[18:0]));
        chk(32'({secondary_port_pins_o, expanded_port_pins_o}), 32'(r[18:0] ^ 19'h7_FFFF));
        chk(32'(taken), 32'h0000_0003);
        stop_test();
    end
endmodule
bind vic_ctrl vic_ctrl_monitor mon_u (.*);
`default_nettype wire

// ---- sim/vic_core_model.sv ----
// core model: remembers which request lines it has seen
`timescale 1ns/100ps
`default_nettype none
module vic_core_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic irq_i,
    input wire logic fiq_i,
    output logic [1:0] taken_o
);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            taken_o <= 2'h0;
        end else begin
            taken_o <= taken_o | {fiq_i, irq_i};
        end
    end
endmodule
`default_nettype wire

// ---- sim/vic_ctrl_monitor.sv ----
// port assertions for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
module vic_ctrl_monitor
    import vic_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [VIC_NUM_INT-1:0] int_src_i,
    input wire logic [VIC_NUM_EXT-1:0] ext_int_i,
    input wire logic [VIC_NUM_EXP-1:0] expanded_port_pins_i,
    input wire logic [VIC_NUM_SEC-1:0] secondary_port_pins_i,
    input wire logic [VIC_NUM_EXP-1:0] expanded_port_pins_o,
    input wire logic [VIC_NUM_EXP-1:0] expanded_port_pins_oe_o,
    input wire logic [VIC_NUM_SEC-1:0] secondary_port_pins_o,
    input wire logic [VIC_NUM_SEC-1:0] secondary_port_pins_oe_o,
    input wire logic irq_o,
    input wire logic fiq_o,
    input wire logic [VIC_SRC_W-1:0] irq_vec_o,
    input wire logic [VIC_SRC_W-1:0] fiq_vec_o,
    input wire logic int_o
);
    logic [4:0] pm_ff;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // shadow of the priority mask
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pm_ff <= VIC_PMASK_RST;
        end else if (wr_i && addr_i == VIC_REG_PMASK) begin
            pm_ff <= wdata_i[4:0];
        end
    end
    // all live sources except the unbonded line two held still
    sequence s_quiet;
        !wr_i && $stable(int_src_i) && $stable(ext_int_i[1:0]) && $stable(ext_int_i[3])
            && $stable({secondary_port_pins_i, expanded_port_pins_i});
    endsequence
    a_pmask_read: assert property (rd_i && addr_i == VIC_REG_PMASK |=> rdata_o == {27'h000_0000, $past(pm_ff)})
        else $error("mask readback wrong");
    a_pmask_zero: assert property (pm_ff == 5'h00 |=> !irq_o && !fiq_o)
        else $error("request with mask zero");
    a_irq_vec_none: assert property (irq_o == (irq_vec_o != VIC_NO_SRC))
        else $error("normal vector and request disagree");
    a_fiq_vec_none: assert property (fiq_o == (fiq_vec_o != VIC_NO_SRC))
        else $error("fast vector and request disagree");
    a_vec_range: assert property ((!irq_o || irq_vec_o < 6'h36) && (!fiq_o || fiq_vec_o < 6'h36))
        else $error("vector beyond last source");
    a_quiet_hold: assert property (s_quiet [*4] |-> $stable(irq_o) && $stable(fiq_o) && $stable(irq_vec_o))
        else $error("request moved without cause");
    a_oe_dir: assert property (wr_i && addr_i == VIC_REG_GP_DIR |=>
        {secondary_port_pins_oe_o, expanded_port_pins_oe_o} == $past(wdata_i[18:0]))
        else $error("pin enable not direction");
    a_out_value: assert property (wr_i && addr_i == VIC_REG_GP_OUT |=>
        {secondary_port_pins_o, expanded_port_pins_o} == $past(wdata_i[18:0]))
        else $error("pin output value wrong");
    c_irq: cover property ($rose(irq_o));
    c_fiq: cover property ($rose(fiq_o));
    c_int: cover property ($rose(int_o));
endmodule
`default_nettype wire
